// ===== sim/rsfs_stage_model.sv
// Purpose: power stage and system monitor beside the supervisor
// Assumes: sensed voltage follows the reference while drives are allowed
// Notes:   the clamp pulls the sense to zero unless ov holds the core sense up; pull-up on the good pin
`timescale 1ns/1ps
module rsfs_stage_model (
    // design side
    input  wire logic [13:0]           core_ref,
    input  wire logic [13:0]           bridge_ref,
    input  wire logic                  core_drive_en,
    input  wire logic                  bridge_drive_en,
    input  wire logic                  low_side_force,
    input  wire logic                  pg_oe_n,
    // bench faults
    input  wire logic [13:0]           drop,
    input  wire logic                  ov,
    // sensed values
    output rsfs_pkg::rsfs_sense_t      core_sense,
    output rsfs_pkg::rsfs_sense_t      bridge_sense,
    output logic                       pg_pin
);
    logic [13:0] cv;
    logic [13:0] bv;
    // an undriven output sits at zero; a persisting fault holds the sense up against the clamp
    assign cv = ov ? 14'h3fff : low_side_force ? 14'h0000 : core_drive_en ? core_ref - drop : 14'h0000;
    assign bv = low_side_force ? 14'h0000 : bridge_drive_en ? bridge_ref : 14'h0000;
    assign core_sense = '{diff: cv, fb: cv};
    assign bridge_sense = '{diff: bv, fb: bv};
    assign pg_pin = pg_oe_n; // open drain with pull-up
endmodule : rsfs_stage_model

// ===== sim/test_regulator_startup_fault_supervisor.sv
// Purpose: self-checking bench for the start-up and fault supervisor
// Assumes: shortened start delay and overcurrent wait
// Notes:   expected targets and ramp times come from an integer model
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("[FAIL] %0t mismatch", $time); end end
module test_regulator_startup_fault_supervisor;
    localparam int DLY = 20;
    logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, rise = 0, fall = 0, sel = 0, p3 = 0, p4 = 0;
    logic fx = 0, sd = 0, sc = 0, ov = 0, oc = 0, os = 0, cde, bde, lsf, oe_n, pg_pin, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [5:0] par_code = 6'h00;
    logic [13:0] drop = 14'h0, cref, bref;
    logic [2:0] phc;
    rsfs_pkg::rsfs_sense_t cs, bs;
    int failures = 0, cmp_count = 0, n, t;
    logic e;
    // clock generator
    initial forever #4 core_clk = ~core_clk;
    rsfs_top #(.START_DELAY_CYC(DLY), .OC_WAIT_CYC(30)) u_rsfs_top (.core_clk(core_clk), .srst(srst),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .en_above_rise(rise), .en_above_fall(fall),
        .interface_select_pin(sel), .phase3_sense_neg(p3), .phase4_sense_neg(p4), .fixed_voltage_select(fx),
        .serial_code_dataline(sd), .serial_code_clockline(sc), .par_code(par_code), .core_sense(cs),
        .bridge_sense(bs), .core_oc(oc), .bridge_oc(1'b0), .open_sense(os), .core_drive_en(cde),
        .bridge_drive_en(bde), .low_side_force(lsf), .phase_count(phc), .core_ref(cref), .bridge_ref(bref),
        .power_ok_flag_in(pg_pin), .power_ok_flag_out(), .power_ok_flag_oe_n(oe_n));
    rsfs_stage_model u_rsfs_stage_model (.core_ref(cref), .bridge_ref(bref), .core_drive_en(cde),
        .bridge_drive_en(bde), .low_side_force(lsf), .pg_oe_n(oe_n), .drop(drop), .ov(ov),
        .core_sense(cs), .bridge_sense(bs), .pg_pin(pg_pin));
    task report_and_stop;
        $display("compares %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    // apb master: hold the request until pready is seen at a rising edge
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    // one start-up from power-on reset; t is the model's core target
    task start(input logic m, input logic q3, input logic q4, input logic [2:0] ph);
        srst <= 1; rise <= 0; fall <= 0; sel <= m; p3 <= q3; p4 <= q4;
        repeat (3) @(posedge core_clk);
        srst <= 0;
        @(posedge core_clk);
        `CHK(oe_n, 1'b0)
        `CHK(cref, 14'h0)
        rise <= 1; fall <= 1;
        n = 0;
        while (oe_n !== 1'b1 && n < 60000) begin @(posedge core_clk); n++; end
        `CHK(n > DLY + (t + 12) / 13 * 125 - 130 && n < DLY + (t + 12) / 13 * 125 + 130, 1'b1)
        `CHK(cref, 14'(t))
        `CHK(cde, 1'b1)
        `CHK(phc, ph)
        `CHK(bde, m)
        apb(rsfs_pkg::OFS_TARGET, 0, 0);
        `CHK(r, {2'b0, m ? 14'(t) : 14'h0, 2'b0, 14'(t)})
        apb(rsfs_pkg::OFS_STATUS, 0, 0);
        `CHK(r[9], m)
        `CHK(r[8], 1'b1)
        `CHK(r[7], 1'b1)
        `CHK(bref, m ? 14'(t) : 14'h0)
    endtask : start
    // watchdog
    initial begin
        repeat (90000) @(posedge core_clk);
        failures++;
        report_and_stop();
    end
    initial begin
        void'($urandom(36));
        n = 50 + $urandom % 12;
        par_code <= 6'(n);
        t = 6200 - n * 100;
        start(0, 0, 1, 3'h3);
        fx <= 1; sd <= 1; sc <= 1; t = 6200 - 7 * 200;
        start(1, 1, 1, 3'h2);
        apb(8'h3c, 0, 0);
        `CHK(e, 1'b1)
        drop <= rsfs_pkg::UV_FALL + 14'h0010;
        repeat (5) @(posedge core_clk);
        `CHK(oe_n, 1'b0)
        `CHK(lsf, 1'b0)
        drop <= rsfs_pkg::UV_RISE - 14'h0010; rise <= 0;
        repeat (5) @(posedge core_clk);
        `CHK(oe_n, 1'b1)
        drop <= 14'h0; ov <= 1;
        repeat (5) @(posedge core_clk);
        `CHK(lsf, 1'b1)
        `CHK(oe_n, 1'b0)
        ov <= 0; rise <= 0; fall <= 0;
        repeat (5) @(posedge core_clk);
        `CHK(lsf, 1'b0)
        rise <= 1; fall <= 1;
        repeat (200) @(posedge core_clk);
        `CHK(oe_n, 1'b0)
        `CHK(cref, 14'h0)
        // open sense line holds off start-up, then overcurrent retries until the latch
        srst <= 1; os <= 1; p3 <= 1; p4 <= 1;
        repeat (3) @(posedge core_clk);
        srst <= 0;
        repeat (20) @(posedge core_clk);
        apb(rsfs_pkg::OFS_STATUS, 0, 0);
        `CHK(r[2:0], 3'h0)
        os <= 0;
        repeat (10) @(posedge core_clk);
        apb(rsfs_pkg::OFS_STATUS, 0, 0);
        `CHK(r[2:0], 3'h2)
        `CHK(phc, 3'h2)
        p3 <= 0; p4 <= 0; oc <= 1;
        repeat (300) @(posedge core_clk);
        `CHK(oe_n, 1'b0)
        `CHK(cde, 1'b0)
        `CHK(phc, 3'h4)
        apb(rsfs_pkg::OFS_STATUS, 0, 0);
        `CHK(r[5], 1'b1)
        `CHK(r[2:0], 3'h6)
        report_and_stop();
    end
endmodule : test_regulator_startup_fault_supervisor

// ===== src/rsfs_pkg.sv
// Purpose: constants, states and carriers for the regulator start-up and fault supervisor
// Assumes: core_clk at 125 MHz; voltages are unsigned codes of 0.25 mV per lsb
// Notes:   the sense codes come from converters outside this block
package rsfs_pkg;
    // timing
    localparam int CLK_MHZ        = 125;
    localparam int START_DELAY_US = 100;
    localparam int START_DELAY_CYC = START_DELAY_US * CLK_MHZ;
    localparam int OC_WAIT_MS     = 12;
    localparam int OC_WAIT_CYC    = OC_WAIT_MS * 1000 * CLK_MHZ;
    localparam int RAMP_TICK_CYC  = CLK_MHZ;   // one microsecond
    // voltage scale
    localparam int LSB_UV         = 250;
    localparam int RAMP_UV_PER_US = 3250;
    localparam int UV_FALL_MV     = 300;
    localparam int UV_RISE_MV     = 250;
    localparam int OV_RELEASE_MV  = 400;
    localparam logic [13:0] RAMP_STEP  = 14'(RAMP_UV_PER_US / LSB_UV);
    localparam logic [13:0] UV_FALL    = 14'(UV_FALL_MV * 1000 / LSB_UV);
    localparam logic [13:0] UV_RISE    = 14'(UV_RISE_MV * 1000 / LSB_UV);
    localparam logic [13:0] OV_RELEASE = 14'(OV_RELEASE_MV * 1000 / LSB_UV);
    // target decode
    localparam logic [13:0] PAR_BASE = 14'h1838;
    localparam logic [13:0] PAR_STEP = 14'h0064;
    localparam logic [13:0] SER_BASE = 14'h1838;
    localparam logic [13:0] SER_STEP = 14'h00c8;
    localparam logic [2:0]  MAX_RETRY = 3'h7;
    // register map
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_TARGET  = 8'h08;
    localparam logic [7:0] OFS_REF     = 8'h0c;
    localparam logic [7:0] OFS_OV_TRIP = 8'h10;
    localparam logic [7:0] OFS_PG_HIGH = 8'h14;
    localparam int CTRL_EN_BIT = 0;
    localparam logic        CTRL_EN_RST = 1'b1;
    localparam logic [13:0] OV_TRIP_RST = 14'h1f40;
    localparam logic [13:0] PG_HIGH_RST = 14'h1e00;
    // phase counts
    localparam logic [2:0] PH_TWO   = 3'h2;
    localparam logic [2:0] PH_THREE = 3'h3;
    localparam logic [2:0] PH_FOUR  = 3'h4;

    typedef enum logic [2:0] {
        S_OFF  = 3'b000,
        S_DET  = 3'b001,
        S_DLY  = 3'b010,
        S_RAMP = 3'b011,
        S_RUN  = 3'b100,
        S_OCW  = 3'b101,
        S_LAT  = 3'b110
    } rsfs_state_t;

    // one output's sensed quantities
    typedef struct packed {
        logic [13:0] diff;   // remote_sense_pos minus remote_sense_return
        logic [13:0] fb;     // feedback_node level
    } rsfs_sense_t;
endpackage : rsfs_pkg

// ===== src/rsfs_top.sv
// Purpose: start-up sequencing and fault supervision for a dual-output buck controller
// Assumes: all inputs synchronous to core_clk; srst is the power-on reset
// Notes:   APB slave, zero wait beyond one access cycle
// Overview of operation
// RULE1: stay off until turn-on comparator rises; hysteresis on falling threshold.
// RULE2: latch parallel or serial mode from select pin on each qualified turn-on rise.
// RULE3: sample phase-3/4 sense before soft-start; phase-4 high three, both high two.
// RULE4: neither phase sense input high selects four active core phases.
// RULE5: begin soft-start only after reset release, phase detect and turn-on.
// RULE6: parallel mode keeps bridge rail off, ramps core to parallel code target.
// RULE7: serial mode samples fixed select, data and clock lines for both targets.
// RULE8: targets stay fixed unless turn-on drops or power-on reset occurs.
// RULE9: load targets at soft-start entry, then wait fixed delay before rise.
// RULE10: after delay ramp both references at constant slope toward targets.
// RULE11: raise power-good once reference reaches target with no fault.
// RULE12: hold an output's switches off while feedback exceeds ramping reference.
// RULE13: output pre-charged above target gets drives only at soft-start end.
// RULE14: power-good low in shutdown and soft-start; high only inside limits.
// RULE15: power-good low on under/over voltage, overcurrent, reset or turn-off.
// RULE16: after over voltage or overcurrent latch, power-good stays low until reset.
// RULE17: over voltage needs sense above both trip level and power-good high limit.
// RULE18: over voltage forces low-side on, power-good low, latches normal switching off.
// RULE19: low-side held until sensed difference under release level; repeats on recurrence.
// RULE20: after over voltage latch, no new soft-start until power-on reset.
// RULE21: undervoltage pulls power-good low at target minus 300mV, releases at minus 250mV.
// RULE22: open sense line shuts down; restart soft-start automatically when cleared.
// RULE23: overcurrent holds drives off 12ms, retries, latches off after seven failures.
// RULE24: all delays and ramp steps come from counts of core_clk.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
module rsfs_top #(
    parameter int START_DELAY_CYC = rsfs_pkg::START_DELAY_CYC,
    parameter int OC_WAIT_CYC     = rsfs_pkg::OC_WAIT_CYC
) (
    // clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 srst,
    // apb slave
    input  wire logic [7:0]           paddr,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    // turn-on comparator and straps
    input  wire logic                 en_above_rise,
    input  wire logic                 en_above_fall,
    input  wire logic                 interface_select_pin,
    input  wire logic                 phase3_sense_neg,
    input  wire logic                 phase4_sense_neg,
    input  wire logic                 fixed_voltage_select,
    input  wire logic                 serial_code_dataline,
    input  wire logic                 serial_code_clockline,
    input  wire logic [5:0]           par_code,
    // output sensing and fault inputs
    input  wire rsfs_pkg::rsfs_sense_t core_sense,
    input  wire rsfs_pkg::rsfs_sense_t bridge_sense,
    input  wire logic                 core_oc,
    input  wire logic                 bridge_oc,
    input  wire logic                 open_sense,
    // drive controls
    output logic                      core_drive_en,
    output logic                      bridge_drive_en,
    output logic                      low_side_force,
    output logic [2:0]                phase_count,
    output logic [13:0]               core_ref,
    output logic [13:0]               bridge_ref,
    // power_ok_flag open-drain pin
    input  wire logic                 power_ok_flag_in,
    output logic                      power_ok_flag_out,
    output logic                      power_ok_flag_oe_n
);
    rsfs_pkg::rsfs_state_t st_q;
    logic        en_ok_q, en_prev_q, mode_q, tgt_vld_q, ctrl_en_q;
    logic [13:0] tgt_core_q, tgt_brg_q, ref_core_q, ref_brg_q;
    logic [13:0] ov_trip_q, pg_high_q;
    logic [20:0] cnt_q;
    logic [7:0]  tick_q;
    logic [2:0]  retry_q, phase_q;
    logic        ov_lat_q, oc_lat_q, low_q, uv_core_q, uv_brg_q, pg_q;
    logic        core_drv_q, brg_drv_q, pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic        en_rise, go, step, ov_core, ov_brg, ov_any, oc_any, active, ramp_done, mode_eff;
    logic [2:0]  ser_idx;
    logic [14:0] core_next, brg_next;

    // qualified turn-on and fault terms
    assign en_rise = en_ok_q & ~en_prev_q;
    // the first target load can share its edge with the mode latch, so decode with the incoming mode
    assign mode_eff = en_rise ? interface_select_pin : mode_q;  // [RULE2] [RULE7]
    assign go      = en_ok_q & ctrl_en_q & ~open_sense;  // [RULE5] [RULE22]
    assign ov_core = (core_sense.diff > ov_trip_q) & (core_sense.diff > pg_high_q);  // [RULE17]
    assign ov_brg  = mode_q & (bridge_sense.diff > ov_trip_q) & (bridge_sense.diff > pg_high_q);
    assign ov_any  = ov_core | ov_brg;
    assign oc_any  = core_oc | (mode_q & bridge_oc);
    assign active  = (st_q == rsfs_pkg::S_DET) | (st_q == rsfs_pkg::S_DLY) |
                     (st_q == rsfs_pkg::S_RAMP) | (st_q == rsfs_pkg::S_RUN);
    assign ser_idx = {fixed_voltage_select, serial_code_dataline, serial_code_clockline};
    assign step    = (st_q == rsfs_pkg::S_RAMP) & (tick_q == 8'(rsfs_pkg::RAMP_TICK_CYC - 1));
    assign core_next = {1'b0, ref_core_q} + {1'b0, rsfs_pkg::RAMP_STEP};
    assign brg_next  = {1'b0, ref_brg_q} + {1'b0, rsfs_pkg::RAMP_STEP};
    assign ramp_done = (ref_core_q == tgt_core_q) & (ref_brg_q == tgt_brg_q);

    // turn-on comparator with hysteresis; dips above the falling level are ignored
    always_ff @(posedge core_clk) begin
        if (srst) begin
            en_ok_q   <= 1'b0;
            en_prev_q <= 1'b0;
        end else begin
            en_prev_q <= en_ok_q;
            if (en_above_rise)
                en_ok_q <= 1'b1;  // [RULE1]
            else if (!en_above_fall)
                en_ok_q <= 1'b0;  // [RULE1]
        end
    end

    // mode follows the select pin only at the turn-on rise
    always_ff @(posedge core_clk) begin
        if (srst)
            mode_q <= 1'b0;
        else if (en_rise)
            mode_q <= interface_select_pin;  // [RULE2]
    end

    // start targets: captured once per turn-on, kept through overcurrent retries
    always_ff @(posedge core_clk) begin
        if (srst || !en_ok_q) begin
            tgt_vld_q  <= 1'b0;  // [RULE8]
            tgt_core_q <= 14'h0000;
            tgt_brg_q  <= 14'h0000;
        end else if (st_q == rsfs_pkg::S_OFF && go && !tgt_vld_q) begin
            tgt_vld_q <= 1'b1;  // [RULE9]
            if (mode_eff) begin
                tgt_core_q <= rsfs_pkg::SER_BASE - 14'(ser_idx) * rsfs_pkg::SER_STEP;  // [RULE7]
                tgt_brg_q  <= rsfs_pkg::SER_BASE - 14'(ser_idx) * rsfs_pkg::SER_STEP;  // [RULE7]
            end else begin
                tgt_core_q <= rsfs_pkg::PAR_BASE - 14'(par_code) * rsfs_pkg::PAR_STEP;  // [RULE6]
                tgt_brg_q  <= 14'h0000;  // [RULE6]
            end
        end
    end

    // sequencer; over voltage outranks overcurrent, which outranks disable
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_q    <= rsfs_pkg::S_OFF;
            cnt_q   <= 21'h000000;
            retry_q <= 3'h0;
        end else if (active && ov_any) begin
            st_q  <= rsfs_pkg::S_LAT;  // [RULE18] [RULE20]
            cnt_q <= 21'h000000;
        end else if (active && oc_any) begin
            st_q    <= rsfs_pkg::S_OCW;  // [RULE23]
            cnt_q   <= 21'h000000;
            retry_q <= retry_q + 3'h1;
        end else if (active && !go) begin
            st_q  <= rsfs_pkg::S_OFF;  // [RULE22]
            cnt_q <= 21'h000000;
        end else begin
            cnt_q <= cnt_q + 21'h000001;  // [RULE24]
            case (st_q)
                rsfs_pkg::S_OFF: begin
                    cnt_q <= 21'h000000;
                    if (go)
                        st_q <= rsfs_pkg::S_DET;  // [RULE5]
                end
                rsfs_pkg::S_DET: begin
                    st_q  <= rsfs_pkg::S_DLY;
                    cnt_q <= 21'h000000;
                end
                rsfs_pkg::S_DLY: begin
                    if (cnt_q == 21'(START_DELAY_CYC - 1)) begin
                        st_q  <= rsfs_pkg::S_RAMP;  // [RULE9]
                        cnt_q <= 21'h000000;
                    end
                end
                rsfs_pkg::S_RAMP: begin
                    if (ramp_done) begin
                        st_q    <= rsfs_pkg::S_RUN;  // [RULE11]
                        retry_q <= 3'h0;
                    end
                end
                rsfs_pkg::S_RUN: cnt_q <= 21'h000000;
                rsfs_pkg::S_OCW: begin
                    if (cnt_q == 21'(OC_WAIT_CYC - 1)) begin
                        cnt_q <= 21'h000000;
                        if (retry_q == rsfs_pkg::MAX_RETRY)
                            st_q <= rsfs_pkg::S_LAT;  // [RULE23]
                        else if (go)
                            st_q <= rsfs_pkg::S_DET;  // [RULE23]
                        else
                            st_q <= rsfs_pkg::S_OFF;
                    end
                end
                rsfs_pkg::S_LAT: cnt_q <= 21'h000000;  // left only by srst
                default: st_q <= rsfs_pkg::S_OFF;
            endcase
        end
    end

    // phase detection while in the detect state
    always_ff @(posedge core_clk) begin
        if (srst)
            phase_q <= rsfs_pkg::PH_FOUR;
        else if (st_q == rsfs_pkg::S_DET) begin
            if (phase4_sense_neg && phase3_sense_neg)
                phase_q <= rsfs_pkg::PH_TWO;  // [RULE3]
            else if (phase4_sense_neg)
                phase_q <= rsfs_pkg::PH_THREE;  // [RULE3]
            else
                phase_q <= rsfs_pkg::PH_FOUR;  // [RULE4]
        end
    end

    // microsecond tick for the ramp
    always_ff @(posedge core_clk) begin
        if (srst || st_q != rsfs_pkg::S_RAMP || step)
            tick_q <= 8'h00;
        else
            tick_q <= tick_q + 8'h01;  // [RULE24]
    end

    // reference ramp, clamped at target so its length scales with the target
    always_ff @(posedge core_clk) begin
        // cleared with the targets on turn-off, so a latched state never holds a reference above zero target
        if (srst || !en_ok_q || st_q == rsfs_pkg::S_OFF || st_q == rsfs_pkg::S_DET) begin  // [RULE8]
            ref_core_q <= 14'h0000;
            ref_brg_q  <= 14'h0000;
        end else if (step) begin
            ref_core_q <= (core_next > {1'b0, tgt_core_q}) ? tgt_core_q : core_next[13:0];  // [RULE10]
            ref_brg_q  <= (brg_next > {1'b0, tgt_brg_q}) ? tgt_brg_q : brg_next[13:0];  // [RULE10]
        end
    end

    // drives: off while a pre-charged output sits above the reference
    always_ff @(posedge core_clk) begin
        if (srst || !(st_q == rsfs_pkg::S_RAMP || st_q == rsfs_pkg::S_RUN)) begin
            core_drv_q <= 1'b0;
            brg_drv_q  <= 1'b0;
        end else if (st_q == rsfs_pkg::S_RUN) begin
            core_drv_q <= 1'b1;  // [RULE13]
            brg_drv_q  <= mode_q;  // [RULE6] [RULE13]
        end else begin
            core_drv_q <= core_drv_q | (ref_core_q > core_sense.fb);  // [RULE12]
            brg_drv_q  <= mode_q & (brg_drv_q | (ref_brg_q > bridge_sense.fb));  // [RULE12]
        end
    end

    // over voltage clamp and latches; a new event wins over the release
    always_ff @(posedge core_clk) begin
        if (srst) begin
            low_q    <= 1'b0;
            ov_lat_q <= 1'b0;
            oc_lat_q <= 1'b0;
        end else begin
            if ((active || st_q == rsfs_pkg::S_LAT) && ov_any) begin
                low_q    <= 1'b1;  // [RULE18] [RULE19]
                ov_lat_q <= 1'b1;
            end else if (core_sense.diff < rsfs_pkg::OV_RELEASE &&
                         (!mode_q || bridge_sense.diff < rsfs_pkg::OV_RELEASE))
                low_q <= 1'b0;  // [RULE19]
            if (st_q == rsfs_pkg::S_OCW && cnt_q == 21'(OC_WAIT_CYC - 1) && retry_q == rsfs_pkg::MAX_RETRY)
                oc_lat_q <= 1'b1;  // [RULE16]
        end
    end

    // undervoltage with a 50 mV window, flag only
    always_ff @(posedge core_clk) begin
        if (srst) begin
            uv_core_q <= 1'b0;
            uv_brg_q  <= 1'b0;
        end else begin
            if ({1'b0, core_sense.diff} + {1'b0, rsfs_pkg::UV_FALL} < {1'b0, tgt_core_q})
                uv_core_q <= 1'b1;  // [RULE21]
            else if ({1'b0, core_sense.diff} + {1'b0, rsfs_pkg::UV_RISE} > {1'b0, tgt_core_q})
                uv_core_q <= 1'b0;  // [RULE21]
            if ({1'b0, bridge_sense.diff} + {1'b0, rsfs_pkg::UV_FALL} < {1'b0, tgt_brg_q})
                uv_brg_q <= 1'b1;
            else if ({1'b0, bridge_sense.diff} + {1'b0, rsfs_pkg::UV_RISE} > {1'b0, tgt_brg_q})
                uv_brg_q <= 1'b0;
        end
    end

    // shared power-good; only the run state with clean limits releases it
    always_ff @(posedge core_clk) begin
        if (srst)
            pg_q <= 1'b0;  // [RULE15]
        else
            pg_q <= (st_q == rsfs_pkg::S_RUN) & en_ok_q & ~uv_core_q & ~(mode_q & uv_brg_q) &
                    ~ov_any & ~oc_any & ~ov_lat_q & ~oc_lat_q;  // [RULE11] [RULE14] [RULE15]
    end

    // apb: ready in the first access cycle, data captured at setup
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= psel & ~penable;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
            if (psel && !penable) begin
                case (paddr)
                    rsfs_pkg::OFS_CTRL:    prdata_q <= {31'h00000000, ctrl_en_q};
                    rsfs_pkg::OFS_STATUS:  prdata_q <= {16'h0000, retry_q, phase_q, mode_q, pg_q,
                                                        power_ok_flag_in, ov_lat_q, oc_lat_q, low_q,
                                                        1'b0, st_q};
                    rsfs_pkg::OFS_TARGET:  prdata_q <= {2'h0, tgt_brg_q, 2'h0, tgt_core_q};
                    rsfs_pkg::OFS_REF:     prdata_q <= {2'h0, ref_brg_q, 2'h0, ref_core_q};
                    rsfs_pkg::OFS_OV_TRIP: prdata_q <= {18'h00000, ov_trip_q};
                    rsfs_pkg::OFS_PG_HIGH: prdata_q <= {18'h00000, pg_high_q};
                    default:               pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    // writable registers take effect at the completing edge only
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ctrl_en_q <= rsfs_pkg::CTRL_EN_RST;
            ov_trip_q <= rsfs_pkg::OV_TRIP_RST;
            pg_high_q <= rsfs_pkg::PG_HIGH_RST;
        end else if (psel && penable && pready_q && pwrite) begin
            case (paddr)
                rsfs_pkg::OFS_CTRL:    ctrl_en_q <= pwdata[rsfs_pkg::CTRL_EN_BIT];
                rsfs_pkg::OFS_OV_TRIP: ov_trip_q <= pwdata[13:0];
                rsfs_pkg::OFS_PG_HIGH: pg_high_q <= pwdata[13:0];
                default:               ctrl_en_q <= ctrl_en_q;
            endcase
        end
    end

    // outputs straight from flops, except power_ok_flag_out tied low
    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign core_drive_en      = core_drv_q;
    assign bridge_drive_en    = brg_drv_q;
    assign low_side_force     = low_q;
    assign phase_count        = phase_q;
    assign core_ref           = ref_core_q;
    assign bridge_ref         = ref_brg_q;
    assign power_ok_flag_out  = 1'b0;
    assign power_ok_flag_oe_n = pg_q;  // released means good

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    chk_en_hyst: assert property (en_ok_q && en_above_fall |=> en_ok_q) // [RULE1]
        else $error("turn-on dropped while above falling level");
    chk_mode_hold: assert property (!en_rise |=> $stable(mode_q)) // [RULE2]
        else $error("mode changed without turn-on rise");
    chk_phase_two: assert property (st_q == rsfs_pkg::S_DET && phase3_sense_neg && phase4_sense_neg |=> phase_q == rsfs_pkg::PH_TWO) // [RULE3]
        else $error("two-phase strap not honoured");
    chk_target_hold: assert property (tgt_vld_q && en_ok_q |=> $stable(tgt_core_q) && $stable(tgt_brg_q)) // [RULE8]
        else $error("target changed while enabled");
    chk_ramp_cap: assert property (ref_core_q <= tgt_core_q && ref_brg_q <= tgt_brg_q) // [RULE10]
        else $error("reference above target");
    chk_ramp_step: assert property (step && ref_core_q < tgt_core_q |=> ref_core_q > $past(ref_core_q)) // [RULE10]
        else $error("reference did not advance on tick");
    chk_pg_soft_start: assert property (st_q != rsfs_pkg::S_RUN |=> !pg_q) // [RULE14]
        else $error("power-good high outside run");
    chk_ov_clamp: assert property (active && ov_any |=> low_q && st_q == rsfs_pkg::S_LAT ##1 !pg_q) // [RULE18]
        else $error("over voltage not clamped");
    chk_ov_latch: assert property (ov_lat_q |=> ov_lat_q && !pg_q) // [RULE16]
        else $error("latch cleared without reset");
    chk_bridge_par: assert property (!mode_q |-> !brg_drv_q && tgt_brg_q == 14'h0000) // [RULE6]
        else $error("bridge active in parallel mode");
    chk_retry_limit: assert property (st_q == rsfs_pkg::S_DET |-> retry_q != rsfs_pkg::MAX_RETRY) // [RULE23]
        else $error("retry after seventh failure");
endmodule : rsfs_top
